// >>> svgss_consts.svh
`ifndef SVGSS_CONSTS_SVH
`define SVGSS_CONSTS_SVH

`define SVGSS_IDX_RST 7'h00
`define SVGSS_IDX_MAX 7'h40
`define SVGSS_IDX_OFF_MAX 7'h04
`define SVGSS_IDX_ON_MAX 7'h30
`define SVGSS_MODE_OFF 2'h0
`define SVGSS_MODE_RUN 2'h1
`define SVGSS_SETUP_PIP 1'b0
`define SVGSS_SETUP_SW 1'b1
`define SVGSS_COND_FIX2 4'h1
`define SVGSS_COND_EXT 4'h2
`define SVGSS_COND_TVAR 4'h3
`define SVGSS_COND_FIX2B 4'h4
`define SVGSS_COND_SPEED 4'h5
`define SVGSS_TLIM_PI_FIX 2'h3
`define SVGSS_SAVE_PERIOD_MIN 30
`define SVGSS_CLK_PERIOD_NS 100
`define SVGSS_SAVE_CYCLES (35'(`SVGSS_SAVE_PERIOD_MIN) * 35'd60 \
    * (35'd1000000000 / 35'(`SVGSS_CLK_PERIOD_NS)))
`define SVGSS_CNT_ONE 35'h000000001
`define SVGSS_CNT_ZERO 35'h000000000

`endif

// >>> svgss_pkg.sv
package svgss_pkg;

    typedef enum logic [0:0] {
        SVGSS_ST_BOOT = 1'b0,
        SVGSS_ST_RUN = 1'b1
    } svgss_state_e;

    typedef struct packed {
        logic gain_setup;
        logic [3:0] cond;
        logic [1:0] tlim;
    } svgss_gain_cfg_s;

    typedef struct packed {
        logic [15:0] level;
        logic [15:0] hyst;
    } svgss_level_s;

endpackage

// >>> svgss_top.sv
`timescale 1ns/1ns
`include "svgss_consts.svh"
module svgss_top import svgss_pkg::*; #(
    parameter logic [34:0] SAVE_CYCLES = `SVGSS_SAVE_CYCLES
) (
    input wire logic SYS_CLK, // drive clock
    input wire logic RST_N, // synchronous reset
    input wire logic [1:0] ADAPT_FILTER_MODE, // adaptive filter mode
    input wire logic FILTER_ENABLE_CONFIG, // enable for index 49..64
    input wire logic ADAPT_UPD_VALID, // adaptive action new index
    input wire logic [6:0] ADAPT_UPD_INDEX, // index from adaptive action
    input wire logic IDX_WR_EN, // host write of the index
    input wire logic [6:0] IDX_WR_DATA, // host index value
    input wire logic [6:0] NVM_STORED_INDEX, // index held in nvm
    input wire logic GAIN_SETUP_SELECT, // 0 PI/P, 1 gain sets
    input wire logic [3:0] GAIN_SWITCH_CONDITION, // condition 0..10
    input wire logic [1:0] TORQUE_LIMIT_SELECT, // torque limit select
    input wire logic GAIN_IN_N, // pin, low = tied to common return
    input wire logic [15:0] TORQUE_VARIATION, // torque command variation
    input wire logic [15:0] COMMAND_SPEED, // command speed magnitude
    input wire logic [15:0] SWITCH_LEVEL, // switching level
    input wire logic [15:0] SWITCH_HYSTERESIS, // switching hysteresis
    output logic [6:0] ADAPT_FREQ_INDEX, // current frequency index
    output logic FILTER_ACTIVE, // adaptive filter enabled
    output logic VEL_P_ACTION, // 1 = P action, 0 = PI
    output logic GAIN2_SELECT, // 1 = second gain set
    output logic NVM_WR_STB, // one-cycle save strobe
    output logic [6:0] NVM_WR_DATA // index to save
);

    svgss_state_e state_r;
    svgss_gain_cfg_s cfg;
    svgss_level_s lvl;
    logic [6:0] idx_r;
    logic adapt_on;
    logic [34:0] save_cnt_r;
    logic gain_s1_r, gain_s2_r, gain_s3_r;
    logic gain_in_r;
    logic tvar_hi_r, spd_hi_r;
    logic gain2_nxt, p_nxt, filt_nxt;

    assign cfg = '{gain_setup: GAIN_SETUP_SELECT,
                   cond: GAIN_SWITCH_CONDITION,
                   tlim: TORQUE_LIMIT_SELECT};
    assign lvl = '{level: SWITCH_LEVEL, hyst: SWITCH_HYSTERESIS};
    assign adapt_on = (ADAPT_FILTER_MODE != `SVGSS_MODE_OFF);

    function automatic logic [6:0] clamp_idx(input logic [6:0] v);
        clamp_idx = (v > `SVGSS_IDX_MAX) ? `SVGSS_IDX_MAX : v;
    endfunction

    // hysteresis comparator: above level+hyst sets, below level-hyst clears
    function automatic logic hyst_cmp(input logic cur,
                                      input logic [15:0] val,
                                      input svgss_level_s l);
        logic [16:0] hi;
        logic [16:0] lo;
        hi = {1'b0, l.level} + {1'b0, l.hyst};
        lo = (l.hyst > l.level) ? 17'h00000 : {1'b0, l.level - l.hyst};
        if ({1'b0, val} > hi) begin
            hyst_cmp = 1'b1;
        end else if ({1'b0, val} < lo) begin
            hyst_cmp = 1'b0;
        end else begin
            hyst_cmp = cur;
        end
    endfunction

    // boot step: one cycle after reset release to fetch the stored index
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= SVGSS_ST_BOOT;
        end else begin
            state_r <= SVGSS_ST_RUN;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            idx_r <= `SVGSS_IDX_RST;
        end else begin
            case (state_r)
                SVGSS_ST_BOOT: begin
                    if (adapt_on) begin
                        idx_r <= clamp_idx(NVM_STORED_INDEX);
                    end
                end
                SVGSS_ST_RUN: begin
                    if (adapt_on) begin
                        // mode 2 holds the index; host writes dropped
                        if (ADAPT_FILTER_MODE == `SVGSS_MODE_RUN
                                && ADAPT_UPD_VALID) begin
                            idx_r <= clamp_idx(ADAPT_UPD_INDEX);
                        end
                    end else if (IDX_WR_EN) begin
                        idx_r <= clamp_idx(IDX_WR_DATA);
                    end
                end
                default: begin
                    idx_r <= idx_r;
                end
            endcase
        end
    end

    always_comb begin
        if (idx_r <= `SVGSS_IDX_OFF_MAX) begin
            filt_nxt = 1'b0;
        end else if (idx_r <= `SVGSS_IDX_ON_MAX) begin
            filt_nxt = 1'b1;
        end else begin
            filt_nxt = FILTER_ENABLE_CONFIG;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FILTER_ACTIVE <= 1'b0;
        end else begin
            FILTER_ACTIVE <= filt_nxt;
        end
    end

    // periodic save; timer restarts whenever adaption is switched off
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            save_cnt_r <= `SVGSS_CNT_ZERO;
            NVM_WR_STB <= 1'b0;
            NVM_WR_DATA <= `SVGSS_IDX_RST;
        end else begin
            NVM_WR_STB <= 1'b0;
            if (!adapt_on || state_r == SVGSS_ST_BOOT) begin
                save_cnt_r <= `SVGSS_CNT_ZERO;
            end else if (save_cnt_r >= SAVE_CYCLES - `SVGSS_CNT_ONE) begin
                save_cnt_r <= `SVGSS_CNT_ZERO;
                NVM_WR_STB <= 1'b1;
                NVM_WR_DATA <= idx_r;
            end else begin
                save_cnt_r <= save_cnt_r + `SVGSS_CNT_ONE;
            end
        end
    end

    // pin synchroniser; level taken once stages two and three agree
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            gain_s1_r <= 1'b1;
            gain_s2_r <= 1'b1;
            gain_s3_r <= 1'b1;
            gain_in_r <= 1'b0;
        end else begin
            gain_s1_r <= GAIN_IN_N;
            gain_s2_r <= gain_s1_r;
            gain_s3_r <= gain_s2_r;
            if (gain_s2_r == gain_s3_r) begin
                gain_in_r <= ~gain_s3_r;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tvar_hi_r <= 1'b0;
            spd_hi_r <= 1'b0;
        end else begin
            tvar_hi_r <= hyst_cmp(tvar_hi_r, TORQUE_VARIATION, lvl);
            spd_hi_r <= hyst_cmp(spd_hi_r, COMMAND_SPEED, lvl);
        end
    end

    always_comb begin
        p_nxt = 1'b0;
        gain2_nxt = 1'b0;
        if (cfg.gain_setup == `SVGSS_SETUP_PIP) begin
            if (cfg.tlim != `SVGSS_TLIM_PI_FIX) begin
                p_nxt = gain_in_r;
            end
        end else begin
            case (cfg.cond)
                `SVGSS_COND_FIX2: gain2_nxt = 1'b1;
                `SVGSS_COND_FIX2B: gain2_nxt = 1'b1;
                `SVGSS_COND_EXT: begin
                    gain2_nxt = gain_in_r
                        && (cfg.tlim != `SVGSS_TLIM_PI_FIX);
                end
                `SVGSS_COND_TVAR: gain2_nxt = tvar_hi_r;
                `SVGSS_COND_SPEED: gain2_nxt = spd_hi_r;
                default: gain2_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            VEL_P_ACTION <= 1'b0;
            GAIN2_SELECT <= 1'b0;
        end else begin
            VEL_P_ACTION <= p_nxt;
            GAIN2_SELECT <= gain2_nxt;
        end
    end

    assign ADAPT_FREQ_INDEX = idx_r;

    a_idx_range: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ADAPT_FREQ_INDEX <= `SVGSS_IDX_MAX)
        else $error("index above 64");

    a_filter_off: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (idx_r <= `SVGSS_IDX_OFF_MAX) |=> !FILTER_ACTIVE)
        else $error("filter active for low index");

    a_filter_on: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (idx_r > `SVGSS_IDX_OFF_MAX && idx_r <= `SVGSS_IDX_ON_MAX)
        |=> FILTER_ACTIVE)
        else $error("filter inactive for mid index");

    a_idx_locked: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (state_r == SVGSS_ST_RUN && adapt_on
            && !(ADAPT_UPD_VALID && ADAPT_FILTER_MODE == `SVGSS_MODE_RUN))
        |=> $stable(idx_r))
        else $error("index changed while adaption owns it");

    a_save_data: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        NVM_WR_STB |-> (NVM_WR_DATA == $past(idx_r) && $past(adapt_on)))
        else $error("save strobe with wrong data");

    a_boot_load: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (state_r == SVGSS_ST_BOOT && adapt_on)
        |=> idx_r == clamp_idx($past(NVM_STORED_INDEX)))
        else $error("stored index not loaded");

    a_pi_fixed: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (!cfg.gain_setup && cfg.tlim == `SVGSS_TLIM_PI_FIX) |=> !VEL_P_ACTION)
        else $error("P action with torque select 3");

    a_p_action: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (!cfg.gain_setup && cfg.tlim != `SVGSS_TLIM_PI_FIX)
        |=> VEL_P_ACTION == $past(gain_in_r))
        else $error("velocity action does not follow input");

    a_ext_gain: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (cfg.gain_setup && cfg.cond == `SVGSS_COND_EXT)
        |=> GAIN2_SELECT == ($past(gain_in_r)
            && $past(cfg.tlim) != `SVGSS_TLIM_PI_FIX))
        else $error("external gain switching wrong");

    a_speed_hyst: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        (spd_hi_r && {1'b0, COMMAND_SPEED} >= {1'b0, SWITCH_LEVEL})
        |=> spd_hi_r)
        else $error("speed selection dropped inside band");
endmodule // svgss_top

// >>> svgss_host_model.sv
`timescale 1ns/1ns
module svgss_host_model (
    input wire logic sys_clk, // drive clock
    input wire logic connect, // close contact to common return
    output logic gain_in_n // gain input pin
);
    initial gain_in_n = 1'b1;
    // contact moves just after an edge; open pin is pulled high
    always @(posedge sys_clk) begin
        #10;
        gain_in_n = ~connect;
    end
endmodule // svgss_host_model

// >>> servo_gain_switch_select_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    err_count++; $display("BAD %s exp %h seen %h", n, e, s); end end
module servo_gain_switch_select_bench import svgss_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, fcfg = 1'b0, uv = 1'b0, we = 1'b0;
    logic setup = 1'b0, conn = 1'b0, pin_n, fact, pact, g2, stb;
    logic [1:0] mode = 2'h0, tlim = 2'h0;
    logic [3:0] cond = 4'h0;
    logic [6:0] ui = 7'h00, wd = 7'h00, nvm = 7'h21, idx, sd;
    logic [15:0] tv = 16'h0000, spd = 16'h0000;
    logic [15:0] lvl = 16'h0064, hys = 16'h000a;
    int err_count = 0, compares = 0;
    always #50 clk = ~clk;
    svgss_host_model host (.sys_clk(clk), .connect(conn), .gain_in_n(pin_n));
    svgss_top #(.SAVE_CYCLES(35'd20)) uut (
        .SYS_CLK(clk), .RST_N(rst_n), .ADAPT_FILTER_MODE(mode),
        .FILTER_ENABLE_CONFIG(fcfg), .ADAPT_UPD_VALID(uv),
        .ADAPT_UPD_INDEX(ui), .IDX_WR_EN(we), .IDX_WR_DATA(wd),
        .NVM_STORED_INDEX(nvm), .GAIN_SETUP_SELECT(setup),
        .GAIN_SWITCH_CONDITION(cond), .TORQUE_LIMIT_SELECT(tlim),
        .GAIN_IN_N(pin_n), .TORQUE_VARIATION(tv), .COMMAND_SPEED(spd),
        .SWITCH_LEVEL(lvl), .SWITCH_HYSTERESIS(hys),
        .ADAPT_FREQ_INDEX(idx), .FILTER_ACTIVE(fact), .VEL_P_ACTION(pact),
        .GAIN2_SELECT(g2), .NVM_WR_STB(stb), .NVM_WR_DATA(sd));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr_idx(input logic [6:0] v);
        we = 1'b1;
        wd = v;
        step(1);
        we = 1'b0;
        step(3);
    endtask
    task automatic upd_idx(input logic [6:0] v);
        uv = 1'b1;
        ui = v;
        step(1);
        uv = 1'b0;
        step(3);
    endtask
    task automatic t_index();
        logic [6:0] v[6] = '{7'h04, 7'h05, 7'h30, 7'h31, 7'h31, 7'h64};
        logic [6:0] e;
        for (int i = 0; i < 6; i++) begin
            fcfg = i[0];
            wr_idx(v[i]);
            e = (v[i] > 7'h40) ? 7'h40 : v[i];
            `CHK("index", e, idx)
            `CHK("active", (e > 7'h04) && (e < 7'h31 || fcfg), fact)
        end
    endtask
    task automatic t_auto();
        mode = 2'h1;
        wr_idx(7'h0a);
        `CHK("refused write", 7'h40, idx)
        upd_idx(7'h14);
        `CHK("auto update", 7'h14, idx)
        mode = 2'h2;
        upd_idx(7'h1e);
        `CHK("hold mode", 7'h14, idx)
        for (int i = 0; i < 40 && stb !== 1'b1; i++) step(1);
        `CHK("save strobe", 1'b1, stb)
        `CHK("save data", 7'h14, sd)
        step(1);
        `CHK("strobe end", 1'b0, stb)
        step(18);
        `CHK("no early save", 1'b0, stb)
        step(1);
        `CHK("save period", 1'b1, stb)
    endtask
    task automatic t_boot();
        mode = 2'h1;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(4);
        `CHK("boot index", 7'h21, idx)
        `CHK("boot active", 1'b1, fact)
        mode = 2'h0;
        step(2);
        wr_idx(7'h07);
        `CHK("cleared index", 7'h07, idx)
        mode = 2'h1;
        upd_idx(7'h0c);
        `CHK("readapt", 7'h0c, idx)
    endtask
    task automatic t_gain0();
        setup = 1'b0;
        cond = 4'h1;
        step(8);
        `CHK("open pi", 1'b0, pact)
        `CHK("first gain", 1'b0, g2)
        conn = 1'b1;
        step(8);
        `CHK("closed p", 1'b1, pact)
        `CHK("cond ignored", 1'b0, g2)
        tlim = 2'h3;
        step(8);
        `CHK("pi fixed", 1'b0, pact)
        tlim = 2'h0;
        conn = 1'b0;
    endtask
    task automatic t_sets();
        logic [3:0] c[5] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'ha};
        setup = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cond = c[i];
            step(8);
            `CHK("fixed gain", (i == 1 || i == 2), g2)
        end
        cond = 4'h2;
        conn = 1'b1;
        step(8);
        `CHK("ext second", 1'b1, g2)
        tlim = 2'h3;
        step(8);
        `CHK("ext forced first", 1'b0, g2)
        tlim = 2'h0;
        conn = 1'b0;
        step(8);
        `CHK("ext released", 1'b0, g2)
    endtask
    task automatic t_level(input logic [3:0] c);
        logic [15:0] v[4] = '{16'h0073, 16'h005f, 16'h0055, 16'h0069};
        cond = c;
        for (int i = 0; i < 4; i++) begin
            tv = (c == 4'h3) ? v[i] : 16'h00c8;
            spd = (c == 4'h3) ? 16'h00c8 : v[i];
            step(8);
            `CHK("level gain", (i < 2), g2)
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        finish_test();
    end
    initial begin
        step(8);
        rst_n = 1'b1;
        step(3);
        `CHK("reset index", 7'h00, idx)
        `CHK("reset strobe", 1'b0, stb)
        t_index();
        t_auto();
        t_boot();
        t_gain0();
        t_sets();
        t_level(4'h3);
        t_level(4'h5);
        finish_test();
    end
endmodule // servo_gain_switch_select_bench
